/* File: logic/tmr2_regs.vh */
// register map, field positions, reset values and timing counts of the timer 2 block
`ifndef TMR2_REGS_VH
`define TMR2_REGS_VH
`define TMR2_ADDR_CTRL 8'hC8
`define TMR2_ADDR_RCAPL 8'hCA
`define TMR2_ADDR_RCAPH 8'hCB
`define TMR2_ADDR_CNTL 8'hCC
`define TMR2_ADDR_CNTH 8'hCD
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXF 6
`define TMR2_BIT_RXSEL 5
`define TMR2_BIT_TXSEL 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CSRC 1
`define TMR2_BIT_CPRL 0
`define TMR2_CTRL_RST 8'h00
`define TMR2_BYTE_RST 8'h00
`define TMR2_STATES 6
`define TMR2_ST_S1 6'h01
`define TMR2_ST_S2 6'h02
`define TMR2_ST_S3 6'h04
`define TMR2_ST_S4 6'h08
`define TMR2_ST_S5 6'h10
`define TMR2_ST_S6 6'h20
`endif

/* File: logic/tmr2_byte_pair.v */
// reload/capture register pair with registered read data
`timescale 1ns/10ps
module tmr2_byte_pair #(
   parameter W = 8
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   input wire ce_i,
   // write ports
   input wire wr_lo_i,
   input wire wr_hi_i,
   input wire [W-1:0] lo_d_i,
   input wire [W-1:0] hi_d_i,
   // read ports
   input wire rd_hi_i,
   output reg [W-1:0] rd_data_o,
   output wire [2*W-1:0] pair_o
);
   reg [W-1:0] lo_q;
   reg [W-1:0] hi_q;
   assign pair_o = {hi_q, lo_q};
   // =====================================
   // storage and registered read
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         lo_q <= {W{1'b0}};
         hi_q <= {W{1'b0}};
         rd_data_o <= {W{1'b0}};
      end else if (ce_i) begin
         if (wr_lo_i) begin
            lo_q <= lo_d_i;
         end
         if (wr_hi_i) begin
            hi_q <= hi_d_i;
         end
         rd_data_o <= rd_hi_i ? hi_q : lo_q;
      end
   end
endmodule

/* File: logic/tmr2_top.v */
// timer 2: auto-reload, capture and baud generator with edge detectors and flag guard
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "tmr2_regs.vh"
module tmr2_top (
   // clock, reset, enable
   input wire clk_sys_i,
   input wire rst_i,
   input wire ce_i,
   // register port
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // cpu instruction status
   input wire ctrl_rmw_i,
   input wire next_instr_m2_i,
   // pins
   input wire external_count_pin_i,
   input wire capture_reload_pin_i,
   // serial port side
   input wire [1:0] serial_mode_i,
   output reg rx_baud_tick_o,
   output reg tx_baud_tick_o,
   // interrupt request
   output reg irq_o
);
   // =====================================
   // overview
   // one machine state per enabled clock, six states to a machine cycle
   // internal clock counts once per machine cycle, baud mode every second state
   // each pin fall passes a latch and a sync stage, giving exactly one pulse
   // the latch is cleared at the transfer state so a later fall is not lost
   // a carry during a control rewrite is parked until the next M2 S1 strobe
   // software clears flags by writing control; a hardware set in the same cycle wins
   // counter writes only land while the counter neither counts nor reloads
   // rx and tx ticks reach the serial port only in its variable-rate modes
   // read data come from one flip-flop stage, the cycle after the read strobe
   // =====================================
   // machine state ring, one-hot S1..S6
   reg [5:0] state_q;
   reg [7:0] ctrl_q;
   reg [7:0] cnt_lo_q;
   reg [7:0] cnt_hi_q;
   reg ext_edge_latch_q;
   reg ext_sync_stage_q;
   reg ext_pin_q;
   reg ev_edge_latch_q;
   reg ev_sync_stage_q;
   reg ev_pin_q;
   reg pend_ovf_q;
   wire [15:0] pair;
   // =====================================
   // helper functions
   // true when the one-hot state ring sits in the given state
   function tmr2_at;
      input [5:0] st;
      input [5:0] code;
      begin
         tmr2_at = (st == code);
      end
   endfunction
   // falling edge between the stored level and the present level
   function tmr2_fall;
      input prev;
      input now;
      begin
         tmr2_fall = prev & ~now;
      end
   endfunction
   // true when a strobe hits the given register offset
   function tmr2_hit;
      input strobe;
      input [7:0] ad;
      input [7:0] offs;
      begin
         tmr2_hit = strobe & (ad == offs);
      end
   endfunction
   // byte returned for a register offset; unmapped offsets read zero
   function [7:0] tmr2_rd_byte;
      input [7:0] ad;
      input [7:0] ctl;
      input [15:0] cnt;
      input [15:0] pr;
      begin
         case (ad)
            `TMR2_ADDR_CTRL: tmr2_rd_byte = ctl;
            `TMR2_ADDR_RCAPL: tmr2_rd_byte = pr[7:0];
            `TMR2_ADDR_RCAPH: tmr2_rd_byte = pr[15:8];
            `TMR2_ADDR_CNTL: tmr2_rd_byte = cnt[7:0];
            `TMR2_ADDR_CNTH: tmr2_rd_byte = cnt[15:8];
            default: tmr2_rd_byte = 8'h00;
         endcase
      end
   endfunction
   // =====================================
   // state ring advance, one state per enabled clock
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= `TMR2_ST_S1;
      end else if (ce_i) begin
         case (state_q)
            `TMR2_ST_S1: state_q <= `TMR2_ST_S2;
            `TMR2_ST_S2: state_q <= `TMR2_ST_S3;
            `TMR2_ST_S3: state_q <= `TMR2_ST_S4;
            `TMR2_ST_S4: state_q <= `TMR2_ST_S5;
            `TMR2_ST_S5: state_q <= `TMR2_ST_S6;
            `TMR2_ST_S6: state_q <= `TMR2_ST_S1;
            default: state_q <= `TMR2_ST_S1;
         endcase
      end
   end
   // =====================================
   // control decode
   wire rx_sel = ctrl_q[`TMR2_BIT_RXSEL];
   wire tx_sel = ctrl_q[`TMR2_BIT_TXSEL];
   // mode selection
   // either select bit overrides the capture select bit
   wire baud_mode = rx_sel | tx_sel;
   wire capt_mode = ~baud_mode & ctrl_q[`TMR2_BIT_CPRL];
   wire run = ctrl_q[`TMR2_BIT_RUN];
   wire exen = ctrl_q[`TMR2_BIT_EXEN];
   // =====================================
   // edge detectors
   // only falls of the count pin advance the counter
   wire ext_fall = tmr2_fall(ext_pin_q, external_count_pin_i);
   wire ev_fall = tmr2_fall(ev_pin_q, capture_reload_pin_i);
   wire ext_count = ext_sync_stage_q & tmr2_at(state_q, `TMR2_ST_S3);
   wire ev_raw = ev_sync_stage_q & tmr2_at(state_q, `TMR2_ST_S4);
   wire ev_pulse = ev_raw & exen;
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ext_pin_q <= 1'b0;
         ev_pin_q <= 1'b0;
         ext_edge_latch_q <= 1'b0;
         ext_sync_stage_q <= 1'b0;
         ev_edge_latch_q <= 1'b0;
         ev_sync_stage_q <= 1'b0;
      end else if (ce_i) begin
         ext_pin_q <= external_count_pin_i;
         ev_pin_q <= capture_reload_pin_i;
         // latch, transfer at S5, clear latch
         if (ext_fall) begin
            ext_edge_latch_q <= 1'b1;
         end else if (state_q == `TMR2_ST_S5) begin
            ext_edge_latch_q <= 1'b0;
         end
         if (state_q == `TMR2_ST_S5) begin
            ext_sync_stage_q <= ext_edge_latch_q;
         end else if (state_q == `TMR2_ST_S3) begin
            ext_sync_stage_q <= 1'b0;
         end
         // latch, transfer at S2, clear latch
         if (ev_fall) begin
            ev_edge_latch_q <= 1'b1;
         end else if (state_q == `TMR2_ST_S2) begin
            ev_edge_latch_q <= 1'b0;
         end
         if (state_q == `TMR2_ST_S2) begin
            ev_sync_stage_q <= ev_edge_latch_q;
         end else if (state_q == `TMR2_ST_S4) begin
            ev_sync_stage_q <= 1'b0;
         end
      end
   end
   // =====================================
   // count enable
   // internal clock in baud mode counts every second state
   wire int_tick = baud_mode ? (state_q[0] | state_q[2] | state_q[4])
                             : (state_q == `TMR2_ST_S6);
   wire src_tick = ctrl_q[`TMR2_BIT_CSRC] ? ext_count : int_tick;
   wire count_en = run & src_tick;
   // counter seen as one word, carry on roll over from all ones
   wire [15:0] cnt_word = {cnt_hi_q, cnt_lo_q};
   wire carry = count_en & (cnt_word == 16'hFFFF);
   // auto-reload mode reloads on carry or enabled pin fall
   wire auto_mode = ~baud_mode & ~capt_mode;
   wire reload_auto = auto_mode & (carry | ev_pulse);
   // baud mode reloads on every carry, pin falls only flag
   wire reload_baud = baud_mode & carry;
   wire reload = reload_auto | reload_baud;
   wire capture = capt_mode & ev_pulse;
   // =====================================
   // register access decode
   wire wr_ctrl = tmr2_hit(wr_i, addr_i, `TMR2_ADDR_CTRL);
   wire wr_rl = tmr2_hit(wr_i, addr_i, `TMR2_ADDR_RCAPL);
   wire wr_rh = tmr2_hit(wr_i, addr_i, `TMR2_ADDR_RCAPH);
   wire wr_cl = tmr2_hit(wr_i, addr_i, `TMR2_ADDR_CNTL);
   wire wr_ch = tmr2_hit(wr_i, addr_i, `TMR2_ADDR_CNTH);
   // capture wins over software write of the pair
   tmr2_byte_pair #(.W(8)) u_pair (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_lo_i(capture | wr_rl),
      .wr_hi_i(capture | wr_rh),
      .lo_d_i(capture ? cnt_lo_q : wdata_i),
      .hi_d_i(capture ? cnt_hi_q : wdata_i),
      .rd_hi_i(addr_i == `TMR2_ADDR_RCAPH),
      .rd_data_o(),
      .pair_o(pair)
   );
   // =====================================
   // counter bytes
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_lo_q <= `TMR2_BYTE_RST;
         cnt_hi_q <= `TMR2_BYTE_RST;
      end else if (ce_i) begin
         if (reload) begin
            cnt_lo_q <= pair[7:0];
            cnt_hi_q <= pair[15:8];
         end else if (count_en) begin
            cnt_lo_q <= cnt_lo_q + 8'h01;
            if (cnt_lo_q == 8'hFF) begin
               cnt_hi_q <= cnt_hi_q + 8'h01;
            end
         end else begin
            if (wr_cl) begin
               cnt_lo_q <= wdata_i;
            end
            if (wr_ch) begin
               cnt_hi_q <= wdata_i;
            end
         end
      end
   end
   // =====================================
   // flags, with guard on the overflow flag during control rewrite
   // baud mode gives no overflow flag
   wire ovf_evt = carry & ~baud_mode;
   // release a parked flag at S1 of the next M2 strobe
   // the cpu also raises that strobe in M3 of a four-cycle instruction
   wire guard_release = pend_ovf_q & ~ctrl_rmw_i & next_instr_m2_i
                        & tmr2_at(state_q, `TMR2_ST_S1);
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `TMR2_CTRL_RST;
         pend_ovf_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_i;
         end
         // hold carry while rewrite in progress
         if (ovf_evt & ctrl_rmw_i) begin
            pend_ovf_q <= 1'b1;
         end else if (guard_release) begin
            pend_ovf_q <= 1'b0;
         end
         if ((ovf_evt & ~ctrl_rmw_i) | guard_release) begin
            ctrl_q[`TMR2_BIT_OVF] <= 1'b1;
         end
         if (ev_pulse) begin
            ctrl_q[`TMR2_BIT_EXF] <= 1'b1;
         end
      end
   end
   // =====================================
   // outputs, each straight from a flip-flop
   // only the variable-rate serial modes take the carry
   wire var_rate = (serial_mode_i == 2'h1) | (serial_mode_i == 2'h3);
   // carry goes to each circuit whose select bit is set
   wire rx_req = carry & baud_mode & rx_sel & var_rate;
   wire tx_req = carry & baud_mode & tx_sel & var_rate;
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rx_baud_tick_o <= 1'b0;
         tx_baud_tick_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         // carry forwarded as a one-cycle tick
         rx_baud_tick_o <= rx_req;
         tx_baud_tick_o <= tx_req;
         irq_o <= ctrl_q[`TMR2_BIT_OVF] | ctrl_q[`TMR2_BIT_EXF];
      end
   end
   // =====================================
   // register read data
   // data stand only in the cycle after the read strobe, zero otherwise
   // pair bytes read back correctly in every mode
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= rd_i ? tmr2_rd_byte(addr_i, ctrl_q, cnt_word, pair) : 8'h00;
      end
   end
endmodule

/* File: tb/tmr2_top_props.sv */
// port checker for the timer 2 block
`timescale 1ns/10ps
module tmr2_props (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   input wire ce_i,
   // register port
   input wire [7:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   // serial side and request
   input wire [1:0] serial_mode_i,
   input wire rx_baud_tick_o,
   input wire tx_baud_tick_o,
   input wire irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // checks
   property p_rst_out;
      $fell(rst_i) |-> !irq_o && !rx_baud_tick_o && !tx_baud_tick_o && rdata_o == 8'h00;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
   property p_freeze;
      !ce_i |=> $stable(irq_o) && $stable(rx_baud_tick_o) && $stable(tx_baud_tick_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while disabled");
   property p_irq_clear;
      $fell(irq_o) |-> ($past(wr_i) && $past(addr_i) == 8'hC8)
         || ($past(wr_i, 2) && $past(addr_i, 2) == 8'hC8);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("request fell unasked");
   property p_rx_pulse;
      rx_baud_tick_o && ce_i |=> !rx_baud_tick_o;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("receive tick too long");
   property p_tx_pulse;
      tx_baud_tick_o && ce_i |=> !tx_baud_tick_o;
   endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("transmit tick too long");
   property p_rx_mode;
      rx_baud_tick_o |-> serial_mode_i[0] || $past(serial_mode_i[0]);
   endproperty
   a_rx_mode: assert property (p_rx_mode) else $error("receive tick in wrong mode");
   property p_tx_mode;
      tx_baud_tick_o |-> serial_mode_i[0] || $past(serial_mode_i[0]);
   endproperty
   a_tx_mode: assert property (p_tx_mode) else $error("transmit tick in wrong mode");
   property p_unmapped;
      rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind tmr2_top tmr2_props i_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
   .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .serial_mode_i(serial_mode_i), .rx_baud_tick_o(rx_baud_tick_o),
   .tx_baud_tick_o(tx_baud_tick_o), .irq_o(irq_o));

/* File: tb/tmr2_serial_model.sv */
// serial port clock input model counting timer 2 ticks
`timescale 1ns/10ps
module tmr2_serial_model (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // ticks from the timer
   input wire rx_tick_i,
   input wire tx_tick_i,
   // totals seen by receive and transmit circuits
   output reg [15:0] rx_cnt_o,
   output reg [15:0] tx_cnt_o
);
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rx_cnt_o <= 16'h0000;
         tx_cnt_o <= 16'h0000;
      end else begin
         rx_cnt_o <= rx_cnt_o + {15'h0, rx_tick_i};
         tx_cnt_o <= tx_cnt_o + {15'h0, tx_tick_i};
      end
   end
endmodule

/* File: tb/timer2_reload_capture_baud_tb_top.sv */
// self-checking bench for the timer 2 block
`timescale 1ns/10ps
module timer2_reload_capture_baud_tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg ce = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg cnt_pin = 1'b1;
   reg cap_pin = 1'b1;
   reg [1:0] smode = 2'h0;
   reg rmw = 1'b0;
   reg m2 = 1'b0;
   reg [7:0] a;
   reg [15:0] rx0;
   reg [15:0] tx0;
   wire [7:0] rdata;
   wire rx_tick;
   wire tx_tick;
   wire irq;
   wire [15:0] rx_cnt;
   wire [15:0] tx_cnt;
   integer failures = 0;
   integer checks = 0;
   tmr2_top i_dut (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ctrl_rmw_i(rmw), .next_instr_m2_i(m2),
      .external_count_pin_i(cnt_pin), .capture_reload_pin_i(cap_pin), .serial_mode_i(smode),
      .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick), .irq_o(irq));
   tmr2_serial_model i_ser (.clk_sys_i(clk), .rst_i(rst), .rx_tick_i(rx_tick),
      .tx_tick_i(tx_tick), .rx_cnt_o(rx_cnt), .tx_cnt_o(tx_cnt));
   // clock and watchdog
   initial forever #50 clk = ~clk;
   initial begin
      #500000;
      failures = failures + 1;
      wrap_up;
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wrr(input [7:0] ad, input [7:0] d);
      begin
         @(posedge clk);
         addr <= ad;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rdr(input [7:0] ad, input [7:0] exp);
      begin
         @(posedge clk);
         addr <= ad;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 chk(rdata, exp);
      end
   endtask
   // pin levels last at least twelve clocks
   task fall(input sel);
      begin
         repeat (12) @(posedge clk);
         if (sel)
            cnt_pin <= 1'b0;
         else
            cap_pin <= 1'b0;
         repeat (12) @(posedge clk);
         cnt_pin <= 1'b1;
         cap_pin <= 1'b1;
      end
   endtask
   task wait_irq;
      integer n;
      begin
         n = 0;
         while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n = n + 1;
         end
         chk({7'h00, irq}, 8'h01);
      end
   endtask
   // tick totals over forty clocks: about twenty when on, none when off
   task baud(input rx_on, input tx_on);
      begin
         // let ticks launched under the old settings drain first
         repeat (3) @(posedge clk);
         #1 rx0 = rx_cnt;
         tx0 = tx_cnt;
         repeat (40) @(posedge clk);
         #1 chk(rx_on ? rx_cnt - rx0 > 16'h0011 && rx_cnt - rx0 < 16'h0016 : rx_cnt == rx0, 8'h01);
         chk(tx_on ? tx_cnt - tx0 > 16'h0011 && tx_cnt - tx0 < 16'h0016 : tx_cnt == tx0, 8'h01);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (a = 8'hC8; a <= 8'hCD; a = a + 8'h01) rdr(a, 8'h00);
      rdr(8'h00, 8'h00);
      wrr(8'hCA, 8'h34);
      wrr(8'hCB, 8'h12);
      wrr(8'hCC, 8'hFE);
      wrr(8'hCD, 8'hFF);
      wrr(8'hC8, 8'h04);
      wait_irq;
      rdr(8'hC8, 8'h84);
      rdr(8'hCD, 8'h12);
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      wrr(8'hC8, 8'h00);
      rdr(8'hC8, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wrr(8'hCC, 8'h55);
      repeat (30) @(posedge clk);
      rdr(8'hCC, 8'h55);
      wrr(8'hC8, 8'h04);
      fall(1'b0);
      rdr(8'hC8, 8'h04);
      wrr(8'hC8, 8'h00);
      wrr(8'hCD, 8'h00);
      wrr(8'hC8, 8'h0C);
      fall(1'b0);
      wait_irq;
      rdr(8'hC8, 8'h4C);
      rdr(8'hCD, 8'h12);
      wrr(8'hC8, 8'h00);
      wrr(8'hCC, 8'h00);
      wrr(8'hCD, 8'h0A);
      wrr(8'hC8, 8'h0D);
      fall(1'b0);
      wait_irq;
      rdr(8'hC8, 8'h4D);
      rdr(8'hCB, 8'h0A);
      wrr(8'hC8, 8'h00);
      wrr(8'hCC, 8'hFF);
      wrr(8'hCD, 8'hFF);
      rmw <= 1'b1;
      wrr(8'hC8, 8'h04);
      repeat (12) @(posedge clk);
      rdr(8'hC8, 8'h04);
      chk({7'h00, irq}, 8'h00);
      rmw <= 1'b0;
      m2 <= 1'b1;
      wait_irq;
      rdr(8'hC8, 8'h84);
      m2 <= 1'b0;
      wrr(8'hC8, 8'h00);
      wrr(8'hCC, 8'h00);
      wrr(8'hCD, 8'h00);
      wrr(8'hC8, 8'h06);
      fall(1'b1);
      fall(1'b1);
      fall(1'b1);
      rdr(8'hCC, 8'h03);
      wrr(8'hC8, 8'h00);
      wrr(8'hCA, 8'hFF);
      wrr(8'hCB, 8'hFF);
      wrr(8'hCC, 8'hFF);
      wrr(8'hCD, 8'hFF);
      smode <= 2'h1;
      wrr(8'hC8, 8'h34);
      baud(1'b1, 1'b1);
      rdr(8'hC8, 8'h34);
      wrr(8'hC8, 8'h24);
      baud(1'b1, 1'b0);
      smode <= 2'h3;
      baud(1'b1, 1'b0);
      smode <= 2'h2;
      baud(1'b0, 1'b0);
      smode <= 2'h1;
      wrr(8'hC8, 8'h14);
      baud(1'b0, 1'b1);
      wrr(8'hC8, 8'h2C);
      fall(1'b0);
      wait_irq;
      rdr(8'hC8, 8'h6C);
      rdr(8'hCA, 8'hFF);
      wrap_up;
   end
endmodule
